// ### logic/tts_pkg.sv
// Package: register map, field layout, timing and carrier types
package tts_pkg;
	// Register byte offsets
	localparam logic [7:0] MODE0_OFS = 8'h00;
	localparam logic [7:0] MODE1_OFS = 8'h04;
	localparam logic [7:0] TCTRL_OFS = 8'h08;
	localparam logic [7:0] CMP0_OFS = 8'h0C;
	localparam logic [7:0] RES0_OFS = 8'h1C;
	localparam logic [7:0] LAST_OFS = 8'h28;
	// Mode register 0 fields
	localparam int M0_EN_BIT = 0;
	localparam int M0_BUSY_BIT = 1;
	localparam int M0_CH_LSB = 2;
	localparam int M0_SCAN_BIT = 4;
	localparam int M0_FOUR_BIT = 5;
	// Timer control fields
	localparam int TC_EN_LSB = 0;
	localparam int TC_OST_LSB = 2;
	// Reset values
	localparam logic [15:0] CMP_RST = 16'hFFFF;
	localparam logic [9:0] RES_RST = 10'h000;
	// Conversion time in clocks: base plus speed code times step
	localparam logic [9:0] CONV_BASE_CYC = 10'h060;
	localparam logic [9:0] CONV_STEP_CYC = 10'h020;
	localparam logic [2:0] BUF_SEQ_LEN = 3'h4;
	localparam logic [15:0] TMR_TOP = 16'hFFFF;

	typedef enum logic {ST_IDLE, ST_CONV} tts_state_type;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} tts_apb_req_type;

	// APB answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tts_apb_rsp_type;

	// Whole state of the sequencer
	typedef struct packed {
		logic en;
		logic busy;
		logic scan;
		logic four;
		logic [1:0] chsel;
		logic [2:0] speed;
		logic [1:0] tmr_en;
		logic [1:0] ovf_stop;
		logic [3:0][15:0] cmp;
		logic [1:0][15:0] tcnt;
		logic [3:0][9:0] res;
		tts_state_type st;
		logic [9:0] ccnt;
		logic [1:0] slot;
		logic [2:0] cnt;
		logic irq;
		logic [1:0] ain;
		logic [31:0] rdata;
	} tts_regs_type;
endpackage : tts_pkg

// ### logic/tts_sequencer.sv
// Timer-triggered four-channel converter sequencer with APB registers
//
// Behaviour
// - Buffer mode converts one input four times into results 0 to 3.
// - Single-trigger buffer: t0m0 starts each; irq and stop after four.
// - Too few matches in single-trigger modes: no irq, keep waiting.
// - Buffer four-trigger: sources map to results 0..3, any order.
// - Four-trigger sequence end raises irq, clears busy, stops.
// - One-shot restart via timer enable; first match sets busy.
// - Free-running timer: convert on every match while enabled.
// - Repeated triggers from one source are each accepted.
// - Single-trigger scan converts from channel 0 up; result index equals channel.
// - Scan single-trigger: t0m0 converts next channel; last gives irq.
// - Match after a finished scan restarts it from channel 0.
// - Scan single-trigger with too few matches: no irq, wait.
// - Scan four-trigger: source index selects channel, arrival order.
// - Scan four-trigger restarts on next match after completion.
// - Clearing enable mid-conversion abandons it, nothing stored.
// - Simultaneous triggers: lowest input converts, rest ignored.
// - Trigger during conversion aborts it; aborted one not counted.
// - Trigger at completion: result stored, counted, irq raised if last.
// - Processor halt does not stop conversion; registers kept.
// - Timer with overflow stop holds zero until re-enabled.
// - Timer without overflow stop wraps to zero, keeps counting.
module tts_sequencer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Register bus
	input tts_pkg::tts_apb_req_type apb_req,
	output tts_pkg::tts_apb_rsp_type apb_rsp,
	// External match triggers: t0m0, t0m1, t1m0, t1m1
	input wire logic [3:0] ext_trig,
	// Converter core
	input wire logic [9:0] adc_data,
	output logic [1:0] analog_in_sel,
	output logic conv_in_progress,
	output logic conv_end_irq,
	// Internal timer match pulses
	output logic [3:0] timer_match
);
	import tts_pkg::*;

	tts_regs_type r_q;
	tts_regs_type r_d;
	logic [1:0] ovf;
	logic [1:0][15:0] tcnt_nx;
	logic [1:0] ten_nx;
	logic [3:0] tmatch;
	logic [3:0] trig;
	logic setup;
	logic access;
	logic mapped;
	logic [2:0] ridx;
	logic done;
	logic tv;
	logic [1:0] idx;
	logic [2:0] req_len;
	logic [2:0] cnt_inc;
	logic [9:0] conv_cyc;

	// Two trigger timers, each with two compare matches
	for (genvar i = 0; i < 2; i++) begin : g_tmr
		assign ovf[i] = r_q.tmr_en[i] && (r_q.tcnt[i] == TMR_TOP);
		// Overflow wraps to zero; the stop option also drops the enable
		assign tcnt_nx[i] = ovf[i] ? 16'h0000 :
			(r_q.tmr_en[i] ? r_q.tcnt[i] + 16'h0001 : r_q.tcnt[i]);
		assign ten_nx[i] = r_q.tmr_en[i] &&
			!(ovf[i] && r_q.ovf_stop[i]);
		for (genvar j = 0; j < 2; j++) begin : g_cmp
			assign tmatch[2*i+j] = r_q.tmr_en[i] &&
				(r_q.tcnt[i] == r_q.cmp[2*i+j]);
		end
	end

	// Trigger gathering and source selection
	assign trig = ext_trig | tmatch;
	assign conv_cyc = CONV_BASE_CYC + 10'(r_q.speed) * CONV_STEP_CYC;
	assign req_len = r_q.scan ? {1'b0, r_q.chsel} + 3'h1 :
		BUF_SEQ_LEN;
	assign done = (r_q.st == ST_CONV) && (r_q.ccnt == 10'h000);

	// Lowest-numbered trigger wins; single-trigger modes see only t0m0
	always_comb begin
		tv = 1'b0;
		idx = 2'h0;
		if (trig[0]) begin
			tv = 1'b1;
		end else if (r_q.four && trig[1]) begin
			tv = 1'b1;
			idx = 2'h1;
		end else if (r_q.four && trig[2]) begin
			tv = 1'b1;
			idx = 2'h2;
		end else if (r_q.four && trig[3]) begin
			tv = 1'b1;
			idx = 2'h3;
		end
	end

	// Bus phase decode
	assign setup = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable;
	assign mapped = (apb_req.paddr[1:0] == 2'h0) &&
		(apb_req.paddr <= LAST_OFS);
	assign ridx = 3'((apb_req.paddr - CMP0_OFS) >> 2);

	// Next-state logic
	always_comb begin
		r_d = r_q;
		r_d.irq = 1'b0;
		cnt_inc = r_q.cnt + 3'h1;
		r_d.tcnt = tcnt_nx;
		r_d.tmr_en = ten_nx;
		// Register reads are latched in the setup phase
		if (setup) begin
			r_d.rdata = 32'h0000_0000;
			if (apb_req.paddr == MODE0_OFS) begin
				r_d.rdata[M0_EN_BIT] = r_q.en;
				r_d.rdata[M0_BUSY_BIT] = r_q.busy;
				r_d.rdata[M0_CH_LSB +: 2] = r_q.chsel;
				r_d.rdata[M0_SCAN_BIT] = r_q.scan;
				r_d.rdata[M0_FOUR_BIT] = r_q.four;
			end else if (apb_req.paddr == MODE1_OFS) begin
				r_d.rdata[2:0] = r_q.speed;
			end else if (apb_req.paddr == TCTRL_OFS) begin
				r_d.rdata[TC_EN_LSB +: 2] = r_q.tmr_en;
				r_d.rdata[TC_OST_LSB +: 2] = r_q.ovf_stop;
			end else if (mapped && apb_req.paddr < RES0_OFS) begin
				r_d.rdata[15:0] = r_q.cmp[ridx[1:0]];
			end else if (mapped) begin
				r_d.rdata[9:0] = r_q.res[ridx[1:0]];
			end
		end
		// Register writes take effect in the access phase
		if (access && apb_req.pwrite) begin
			if (apb_req.paddr == MODE0_OFS) begin
				r_d.en = apb_req.pwdata[M0_EN_BIT];
				r_d.chsel = apb_req.pwdata[M0_CH_LSB +: 2];
				r_d.scan = apb_req.pwdata[M0_SCAN_BIT];
				r_d.four = apb_req.pwdata[M0_FOUR_BIT];
				r_d.cnt = 3'h0;
			end else if (apb_req.paddr == MODE1_OFS) begin
				r_d.speed = apb_req.pwdata[2:0];
			end else if (apb_req.paddr == TCTRL_OFS) begin
				// Setting the enable restarts a stopped one-shot timer
				r_d.tmr_en = apb_req.pwdata[TC_EN_LSB +: 2];
				r_d.ovf_stop = apb_req.pwdata[TC_OST_LSB +: 2];
			end else if (mapped && apb_req.paddr < RES0_OFS &&
				apb_req.paddr >= CMP0_OFS) begin
				r_d.cmp[ridx[1:0]] = apb_req.pwdata[15:0];
			end
		end
		// Sequencer; runs regardless of processor halt
		if (!r_d.en) begin
			// Disable abandons conversion, nothing stored
			r_d.st = ST_IDLE;
			r_d.busy = 1'b0;
			r_d.cnt = 3'h0;
		end else begin
			if (done) begin
				// Completion stores into the slot chosen at start
				r_d.res[r_q.slot] = adc_data;
				r_d.st = ST_IDLE;
				if (cnt_inc >= req_len) begin
					r_d.irq = 1'b1;
					r_d.busy = 1'b0;
					r_d.cnt = 3'h0;
				end else begin
					r_d.cnt = cnt_inc;
				end
			end
			// A trigger starts a conversion, aborting any running one
			if (tv) begin
				r_d.st = ST_CONV;
				r_d.busy = 1'b1;
				r_d.ccnt = conv_cyc - 10'h001;
				if (r_q.four) begin
					r_d.slot = idx;
					r_d.ain = r_q.scan ? idx : r_q.chsel;
				end else begin
					r_d.slot = r_d.cnt[1:0];
					r_d.ain = r_q.scan ? r_d.cnt[1:0] : r_q.chsel;
				end
			end else if (r_q.st == ST_CONV && !done) begin
				r_d.ccnt = r_q.ccnt - 10'h001;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			r_q <= '0;
			r_q.cmp <= {4{CMP_RST}};
			r_q.res <= {4{RES_RST}};
			r_q.st <= ST_IDLE;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs
	assign apb_rsp.prdata = r_q.rdata;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = access && !mapped;
	assign analog_in_sel = r_q.ain;
	assign conv_in_progress = r_q.busy;
	assign conv_end_irq = r_q.irq;
	assign timer_match = tmatch;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// Sequence end leaves the sequencer idle unless a trigger coincided
	a_irq_clears_busy: assert property (
		conv_end_irq |-> (!conv_in_progress && r_q.st == ST_IDLE) ||
		$past(tv))
		else $error("irq without ending sequence");

	// The end pulse lasts one cycle
	a_irq_pulse: assert property (
		conv_end_irq |=> !conv_end_irq)
		else $error("irq longer than one cycle");

	// Busy drops only at sequence end or on disable
	a_busy_fall: assert property (
		$fell(conv_in_progress) |-> conv_end_irq || !r_q.en)
		else $error("busy dropped mid-sequence");

	// Count is cleared when the sequence completes
	a_irq_resets_cnt: assert property (
		conv_end_irq |-> r_q.cnt == 3'h0)
		else $error("count not cleared at end");

	// Disable write abandons the running conversion
	a_disable_nostore: assert property (
		access && apb_req.pwrite && apb_req.paddr == MODE0_OFS &&
		!apb_req.pwdata[M0_EN_BIT] |=>
		$stable(r_q.res) && r_q.st == ST_IDLE)
		else $error("result stored after disable");

	// A cleared enable keeps the sequencer idle
	a_disabled_idle: assert property (
		!r_q.en |-> r_q.st == ST_IDLE && !conv_in_progress)
		else $error("converting while disabled");

	// Single-trigger modes start only on t0m0
	a_single_source: assert property (
		r_q.en && !r_q.four && !trig[0] && r_q.st == ST_IDLE |=>
		r_q.st == ST_IDLE)
		else $error("single mode started without t0m0");

	// Every t0m0 pulse starts a conversion, even back to back
	a_repeat_accept: assert property (
		r_q.en && trig[0] && !access |=>
		r_q.st == ST_CONV && conv_in_progress)
		else $error("repeated trigger not accepted");

	// Any accepted trigger sets busy
	a_start_busy: assert property (
		r_q.en && tv && !access |=> conv_in_progress)
		else $error("trigger did not set busy");

	// Lowest source wins a tie
	a_lowest_wins: assert property (
		r_q.en && r_q.four && trig[0] && trig[1] && !access |=>
		r_q.slot == 2'h0)
		else $error("simultaneous trigger picked wrong source");

	// Fourth source lands in the fourth result
	a_four_slot: assert property (
		r_q.en && r_q.four && trig == 4'h8 && !access |=>
		r_q.slot == 2'h3)
		else $error("four-trigger slot wrong");

	// Scan channel always equals the result slot
	a_scan_chan: assert property (
		r_q.st == ST_CONV && r_q.scan |-> r_q.ain == r_q.slot)
		else $error("scan channel differs from slot");

	// Scan four-trigger: second source selects channel 1
	a_scan_four_chan: assert property (
		r_q.en && r_q.four && r_q.scan && trig == 4'h2 && !access |=>
		analog_in_sel == 2'h1)
		else $error("scan four-trigger channel wrong");

	// A new single-trigger scan begins at channel 0
	a_scan_restart: assert property (
		r_q.en && r_q.scan && !r_q.four && r_q.cnt == 3'h0 &&
		r_q.st == ST_IDLE && trig[0] && !access |=>
		analog_in_sel == 2'h0)
		else $error("scan did not restart at channel 0");

	// Last scan channel raises the end pulse
	a_scan_last: assert property (
		r_q.en && r_q.scan && done && !access &&
		r_q.cnt == {1'b0, r_q.chsel} |=> conv_end_irq)
		else $error("scan end without irq");

	// Earlier scan channels raise no end pulse
	a_scan_early: assert property (
		r_q.en && r_q.scan && done &&
		r_q.cnt < {1'b0, r_q.chsel} |=> !conv_end_irq)
		else $error("irq before scan complete");

	// Fewer than four buffer conversions raise no end pulse
	a_buf_early: assert property (
		r_q.en && !r_q.scan && done && r_q.cnt < 3'h3 |=>
		!conv_end_irq)
		else $error("irq before four conversions");

	// Scan four-trigger restarts on the next match
	a_loop_restart: assert property (
		r_q.en && r_q.four && r_q.scan && r_q.cnt == 3'h0 &&
		r_q.st == ST_IDLE && trig[0] && !access |=>
		conv_in_progress && analog_in_sel == 2'h0)
		else $error("scan four-trigger did not restart");

	// Trigger at completion still counts and ends the sequence
	a_coincide: assert property (
		r_q.en && done && tv && !access &&
		r_q.cnt == req_len - 3'h1 |=>
		conv_end_irq && r_q.st == ST_CONV)
		else $error("coinciding trigger lost completion");

	// Completion stores the converter value
	a_done_store: assert property (
		r_q.en && done && !(access && apb_req.pwrite &&
		apb_req.paddr == MODE0_OFS) |=>
		r_q.res[$past(r_q.slot)] == $past(adc_data))
		else $error("completed result not stored");

	// Abort restarts the conversion without counting
	a_abort_nocount: assert property (
		r_q.en && r_q.st == ST_CONV && !done && tv && !access |=>
		$stable(r_q.cnt) && r_q.st == ST_CONV)
		else $error("aborted conversion counted");

	// An undisturbed conversion keeps counting down
	a_count_down: assert property (
		r_q.en && r_q.st == ST_CONV && !done && !tv && !access |=>
		r_q.ccnt == $past(r_q.ccnt) - 10'h001)
		else $error("conversion stalled");

	// Stopped timers hold their count and stay quiet
	for (genvar i = 0; i < 2; i++) begin : g_tmr_chk
		a_tmr_hold: assert property (
			!r_q.tmr_en[i] && !access |=> $stable(r_q.tcnt[i]))
			else $error("stopped timer counted");
		a_tmr_quiet: assert property (
			!r_q.tmr_en[i] |-> timer_match[2*i+1 -: 2] == 2'h0)
			else $error("match from stopped timer");
	end

	// Overflow stop holds zero and drops the enable
	a_ovf_stop: assert property (
		ovf[0] && r_q.ovf_stop[0] && !access |=>
		r_q.tcnt[0] == 16'h0000 && !r_q.tmr_en[0] ##1
		r_q.tcnt[0] == 16'h0000)
		else $error("timer did not stop at overflow");

	// Without overflow stop the timer wraps and counts on
	a_ovf_wrap: assert property (
		ovf[1] && !r_q.ovf_stop[1] && !access |=>
		r_q.tcnt[1] == 16'h0000 ##1 r_q.tcnt[1] == 16'h0001)
		else $error("timer did not wrap");
endmodule : tts_sequencer

// ### dv/tts_trig_src.sv
// Match trigger source and converter core model for the sequencer bench
module tts_trig_src (
	// Clock
	input wire logic sys_clk,
	// Bench commands
	input wire logic [3:0] fire,
	input wire logic [9:0] val,
	// Sequencer side
	input wire logic busy,
	output logic [3:0] ext_trig,
	output logic [9:0] adc_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// One-cycle match pulses; the bench spaces them
	always @(posedge sys_clk) ext_trig <= fire;
	// Result only meaningful while converting, inverted otherwise
	assign adc_data = busy ? val : ~val;
endmodule : tts_trig_src

// ### dv/testbench.sv
// Testbench: APB tasks and timer-trigger sequencing tests
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import tts_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	tts_apb_req_type req = '0;
	tts_apb_rsp_type rsp;
	logic [3:0] fire = 4'h0;
	logic [9:0] val = 10'h000;
	logic [3:0] ext_trig, tm;
	logic [9:0] adc_data;
	logic [1:0] sel;
	logic busy, irq, er;
	logic [31:0] rd;
	int failures = 0;
	int cmp_count = 0;
	int irqs = 0;

	// Clock at 50 MHz
	always #10 sys_clk = ~sys_clk;

	tts_sequencer dut_u (.sys_clk(sys_clk), .srst(srst), .apb_req(req),
		.apb_rsp(rsp), .ext_trig(ext_trig), .adc_data(adc_data),
		.analog_in_sel(sel), .conv_in_progress(busy),
		.conv_end_irq(irq), .timer_match(tm));
	tts_trig_src src_u (.sys_clk(sys_clk), .fire(fire), .val(val),
		.busy(busy), .ext_trig(ext_trig), .adc_data(adc_data));

	// Counts end-of-sequence pulses
	always @(posedge sys_clk) if (irq === 1'b1) irqs <= irqs + 1;

	// One APB transfer, then one idle cycle
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do @(posedge sys_clk); while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
		@(posedge sys_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			$display("wrong value %s expected %h seen %h", n, x, g);
			failures++;
		end
	endtask : chk

	task automatic rdc(input string n, input logic [7:0] a,
		input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(n, x, q);
	endtask : rdc

	// Pulse the given sources with a result value, then idle
	task automatic trig(input logic [3:0] s, input logic [9:0] v,
		input int gap);
		val <= v;
		fire <= s;
		@(posedge sys_clk);
		fire <= 4'h0;
		repeat (gap) @(posedge sys_clk);
	endtask : trig

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rdc("mode0", MODE0_OFS, 32'h0);
		rdc("cmp0", CMP0_OFS, {16'h0, CMP_RST});
		apb(1'b0, LAST_OFS + 8'h04, 32'h0, rd, er);
		chk("pslverr", 32'h1, {31'h0, er});
		$display("test reset done");
		wr(MODE0_OFS, 32'h9);
		for (int i = 0; i < 4; i++) begin
			chk("irqs", 0, irqs);
			trig(4'h1, 10'h100 + 10'(i), 110);
		end
		chk("irqs", 1, irqs);
		chk("sel", 2, {30'h0, sel});
		for (int i = 0; i < 4; i++)
			rdc("res", RES0_OFS + 8'(4 * i), 32'h100 + i);
		$display("test buffer single done");
		wr(MODE0_OFS, 32'h21);
		trig(4'hC, 10'h2A2, 110);
		trig(4'h8, 10'h2B3, 110);
		trig(4'h1, 10'h2C0, 110);
		chk("irqs", 1, irqs);
		trig(4'h2, 10'h2D1, 110);
		chk("irqs", 2, irqs);
		rdc("mode0", MODE0_OFS, 32'h21);
		rdc("res0", RES0_OFS, 32'h2C0);
		rdc("res1", RES0_OFS + 8'h04, 32'h2D1);
		rdc("res2", RES0_OFS + 8'h08, 32'h2A2);
		rdc("res3", RES0_OFS + 8'h0C, 32'h2B3);
		trig(4'h4, 10'h3E2, 5);
		chk("busy", 1, {31'h0, busy});
		repeat (110) @(posedge sys_clk);
		trig(4'h3, 10'h3F0, 110);
		rdc("res0", RES0_OFS, 32'h3F0);
		chk("irqs", 2, irqs);
		$display("test buffer four done");
		wr(MODE0_OFS, 32'h1);
		trig(4'h1, 10'h155, 40);
		trig(4'h1, 10'h166, 110);
		rdc("res0", RES0_OFS, 32'h166);
		repeat (2) trig(4'h1, 10'h177, 110);
		chk("irqs", 2, irqs);
		trig(4'h1, 10'h177, 110);
		chk("irqs", 3, irqs);
		wr(MODE0_OFS, 32'h1);
		trig(4'h1, 10'h199, 30);
		wr(MODE0_OFS, 32'h0);
		repeat (100) @(posedge sys_clk);
		rdc("res0", RES0_OFS, 32'h166);
		chk("busy", 0, {31'h0, busy});
		$display("test abort done");
		wr(MODE0_OFS, 32'h15);
		for (int i = 0; i < 3; i++) begin
			trig(4'h1, 10'h200 + 10'(i), 5);
			chk("sel", i % 2, {30'h0, sel});
			repeat (105) @(posedge sys_clk);
			if (i == 0)
				chk("irqs", 3, irqs);
		end
		chk("irqs", 4, irqs);
		rdc("res0", RES0_OFS, 32'h202);
		rdc("res1", RES0_OFS + 8'h04, 32'h201);
		wr(MODE0_OFS, 32'h35);
		trig(4'h2, 10'h311, 5);
		chk("sel", 1, {30'h0, sel});
		repeat (105) @(posedge sys_clk);
		trig(4'h1, 10'h300, 110);
		chk("irqs", 5, irqs);
		rdc("res1", RES0_OFS + 8'h04, 32'h311);
		$display("test scan done");
		wr(CMP0_OFS, 32'h20);
		wr(TCTRL_OFS, 32'h1);
		rdc("tctrl", TCTRL_OFS, 32'h1);
		for (int k = 0; k < 60 && tm[0] !== 1'b1; k++)
			@(posedge sys_clk);
		chk("match", 1, {31'h0, tm[0]});
		$display("test timer done");
		report_and_stop();
	end
endmodule : testbench
